// ---- core/link_test_pattern_gen.sv ----
// Serial link test-pattern generator, transmit side of the lanes
`timescale 1ns/10ps
module link_test_pattern_gen #(
	parameter int LANES   = 5,
	parameter int OCT_PF  = 2,
	parameter int FRM_PMF = 10
) (
	// Clock and reset
	input  wire logic                         clk_sys_i,
	input  wire logic                         rst_i,
	// Configuration
	input  wire logic [link_test_pkg::SEL_W-1:0] link_test_select_i,
	input  wire logic                         link_enable_i,
	input  wire logic [5:0]                   decimation_i,
	input  wire logic                         ddr_i,
	input  wire logic                         packing_mode_select_i,
	// Link pins and formatter
	input  wire logic                         sync_req_n_i,
	input  wire logic                         sysref_i,
	input  wire logic [LANES*8-1:0]           sample_data_i,
	// Serializer side
	output logic      [LANES*8-1:0]           lane_octet_o,
	output logic      [LANES-1:0]             lane_ctrl_o,
	output logic      [LANES*10-1:0]          lane_raw_o,
	output logic                              lane_bypass_o,
	output logic      [LANES-1:0]             lane_power_o
);
	import link_test_pkg::*;

	typedef enum logic [1:0] {ST_SYNC, ST_WAIT, ST_ALIGN, ST_DATA} link_st_t;

	typedef struct packed {
		logic                          sync_meta;
		logic                          sync_n;
		logic                          sref_meta;
		logic                          sref_s;
		logic                          sref_d;
		link_st_t                      st;
		logic [3:0]                    mode;
		logic [7:0]                    oct_cnt;
		logic [7:0]                    frm_cnt;
		logic [1:0]                    mf_cnt;
		logic [7:0]                    ramp;
		logic [3:0]                    rpat_idx;
		logic [LANES-1:0][PRBS_W-1:0]  lfsr;
		logic [LANES-1:0][7:0]         octet;
		logic [LANES-1:0]              ctl;
		logic [LANES-1:0][SYM_W-1:0]   raw;
		logic                          bypass;
		logic [LANES-1:0]              power;
	} state_t;

	state_t q_reg;
	state_t q_next;

	logic sref_rise;
	logic oct_last;
	logic frm_last;
	logic lmfc_end;
	logic mode_chg;
	logic is_prbs;
	logic is_link;
	logic [2:0] lanes_need;

	assign sref_rise = q_reg.sref_s & ~q_reg.sref_d;
	assign oct_last  = q_reg.oct_cnt == 8'(OCT_PF - 1);
	assign frm_last  = q_reg.frm_cnt == 8'(FRM_PMF - 1);
	assign lmfc_end  = oct_last & frm_last & ~sref_rise;
	assign mode_chg  = link_test_select_i != q_reg.mode;
	assign is_prbs   = q_reg.mode == MODE_PRBS7 || q_reg.mode == MODE_PRBS15
		|| q_reg.mode == MODE_PRBS23;
	assign is_link   = !is_prbs && q_reg.mode != MODE_D21_5
		&& q_reg.mode != MODE_K28_5 && q_reg.mode != MODE_RPAT;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic [PRBS_W-1:0] s;
		logic              nb;
		int                ta;
		int                tb;
		logic [7:0]        lo;
		s  = '0;
		nb = 1'b0;
		ta = PRBS7_A;
		tb = PRBS7_B;
		lo = '0;
		q_next = q_reg;
		// Both pins come from outside; sync reads its second stage only, sysref its second and third
		q_next.sync_meta = sync_req_n_i;
		q_next.sync_n    = q_reg.sync_meta;
		q_next.sref_meta = sysref_i;
		q_next.sref_s    = q_reg.sref_meta;
		q_next.sref_d    = q_reg.sref_s;
		q_next.mode      = link_test_select_i;

		if (sref_rise) begin
			q_next.oct_cnt = '0;
			q_next.frm_cnt = '0;
		end else if (oct_last) begin
			q_next.oct_cnt = '0;
			q_next.frm_cnt = frm_last ? 8'h00 : q_reg.frm_cnt + 8'h01;
		end else begin
			q_next.oct_cnt = q_reg.oct_cnt + 8'h01;
		end

		case (q_reg.st)
			ST_SYNC: begin
				if (q_reg.sync_n && link_enable_i) begin
					q_next.st = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (lmfc_end) begin
					q_next.st     = ST_ALIGN;
					q_next.mf_cnt = '0;
				end
			end
			ST_ALIGN: begin
				if (lmfc_end) begin
					q_next.mf_cnt = q_reg.mf_cnt + 2'h1;
					if (q_reg.mf_cnt == ALIGN_MF_LAST
						&& q_reg.mode != MODE_REP_ALIGN) begin
						q_next.st = ST_DATA;
					end
				end
			end
			ST_DATA: begin
				q_next.st = ST_DATA;
			end
			default: begin
				q_next.st = ST_SYNC;
			end
		endcase
		// request resyncs; mode entry forces sync
		if (!q_reg.sync_n || !link_enable_i || mode_chg) begin
			q_next.st = ST_SYNC;
		end

		// ramp starts at zero after alignment
		q_next.ramp = (q_reg.st == ST_DATA) ? q_reg.ramp + 8'h01 : RAMP_START;
		q_next.rpat_idx = (q_reg.rpat_idx == RPAT_LAST) ? 4'h0
			: q_reg.rpat_idx + 4'h1;

		case (q_reg.mode)
			MODE_PRBS15: begin
				ta = PRBS15_A;
				tb = PRBS15_B;
			end
			MODE_PRBS23: begin
				ta = PRBS23_A;
				tb = PRBS23_B;
			end
			default: begin
				ta = PRBS7_A;
				tb = PRBS7_B;
			end
		endcase

		for (int i = 0; i < LANES; i++) begin
			s = q_reg.lfsr[i];
			for (int b = 0; b < SYM_W; b++) begin
				nb = s[ta-1] ^ s[tb-1];
				s  = {s[PRBS_W-2:0], nb};
				q_next.raw[i][SYM_W-1-b] = nb;
			end
			q_next.lfsr[i] = s;
			if (mode_chg) begin
				q_next.lfsr[i] = {SEED_HI ^ 16'(i), 7'(i + 1)};
			end

			lo = {5'h00, 2'(i), packing_mode_select_i};
			q_next.ctl[i]   = 1'b0;
			q_next.octet[i] = sample_data_i[i*8 +: 8];
			if (q_reg.mode == MODE_D21_5) begin
				q_next.octet[i] = CHAR_D21_5;
			end else if (q_reg.mode == MODE_K28_5) begin
				q_next.octet[i] = CHAR_K28_5;
				q_next.ctl[i]   = 1'b1;
			end else if (q_reg.mode == MODE_RPAT) begin
				q_next.octet[i] = RPAT_OCTETS[q_reg.rpat_idx];
			end else if (is_prbs) begin
				q_next.octet[i] = '0;
			end else if (q_reg.st == ST_SYNC || q_reg.st == ST_WAIT) begin
				q_next.octet[i] = CHAR_K28_5;
				q_next.ctl[i]   = 1'b1;
			end else if (q_reg.st == ST_ALIGN) begin
				q_next.octet[i] = {q_reg.frm_cnt[3:0], q_reg.oct_cnt[3:0]};
				if (q_reg.oct_cnt == '0 && q_reg.frm_cnt == '0) begin
					q_next.octet[i] = CHAR_K28_0;
					q_next.ctl[i]   = 1'b1;
				end else if (oct_last && frm_last) begin
					q_next.octet[i] = CHAR_K28_3;
					q_next.ctl[i]   = 1'b1;
				end
			end else if (q_reg.mode == MODE_RAMP) begin
				q_next.octet[i] = q_reg.ramp;
			end else if (q_reg.mode == MODE_TRANSPORT && decimation_i > 6'd1)
			begin
				if (q_reg.frm_cnt == '0) begin
					q_next.octet[i] = oct_last ? lo : TPORT_LO;
				end else begin
					q_next.octet[i] = oct_last ? TPORT_LO : TPORT_HI;
				end
			end
		end
		q_next.bypass = is_prbs;

		case (decimation_i)
			6'd4:    lanes_need = LANES_DEC4;
			6'd8:    lanes_need = LANES_DEC8;
			6'd10:   lanes_need = LANES_DEC10;
			default: lanes_need = LANES_DECHI;
		endcase
		if (ddr_i) begin
			lanes_need = (lanes_need + 3'h1) >> 1;
		end
		for (int i = 0; i < LANES; i++) begin
			q_next.power[i] = 3'(i) < lanes_need;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			q_reg          <= '0;
			q_reg.sync_n   <= 1'b1;
			q_reg.sync_meta <= 1'b1;
			q_reg.st       <= ST_SYNC;
			for (int i = 0; i < LANES; i++) begin
				q_reg.lfsr[i] <= {SEED_HI ^ 16'(i), 7'(i + 1)};
			end
		end else begin
			q_reg <= q_next;
		end
	end

	assign lane_octet_o  = q_reg.octet;
	assign lane_ctrl_o   = q_reg.ctl;
	assign lane_raw_o    = q_reg.raw;
	assign lane_bypass_o = q_reg.bypass;
	assign lane_power_o  = q_reg.power;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	AST_K_IN_SYNC: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(is_link && q_reg.st == ST_SYNC) |=>
		(lane_ctrl_o == '1 && lane_octet_o[7:0] == CHAR_K28_5))
		else $error("K28.5 not sent during sync");
	AST_RAMP_STEP: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(q_reg.mode == MODE_RAMP && q_reg.st == ST_DATA && !mode_chg)[*2] |=>
		(lane_octet_o[7:0] == $past(lane_octet_o[7:0]) + 8'h01
		&& lane_octet_o[15:8] == lane_octet_o[7:0]))
		else $error("Ramp octet did not step");
	AST_PRBS_BYP: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		is_prbs |=> lane_bypass_o) else $error("PRBS not bypassed");
	AST_REP_LOOP: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(q_reg.mode == MODE_REP_ALIGN && q_reg.st == ST_ALIGN && lmfc_end
		&& q_reg.sync_n && link_enable_i && !mode_chg) |=>
		q_reg.st == ST_ALIGN) else $error("Alignment did not repeat");
	AST_REP_ENTRY: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(link_test_select_i == MODE_REP_ALIGN && mode_chg) |=>
		q_reg.st == ST_SYNC) else $error("Entry did not force sync");
	AST_WAIT_HOLD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(q_reg.st == ST_WAIT && q_reg.sync_n && link_enable_i && !mode_chg
		&& !lmfc_end) |=> q_reg.st == ST_WAIT)
		else $error("Left wait before boundary");
	AST_SEED: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		q_reg.lfsr[0] != '0) else $error("PRBS register stuck zero");
	AST_SYSREF: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		sref_rise |=> (q_reg.oct_cnt == '0 && q_reg.frm_cnt == '0))
		else $error("LMFC not aligned to SYSREF");
	AST_RPAT: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(q_reg.mode == MODE_RPAT && q_reg.rpat_idx == 4'h0) |=>
		lane_octet_o[7:0] == RPAT_OCTETS[0])
		else $error("RPAT start octet wrong");
	AST_D21: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		q_reg.mode == MODE_D21_5 |=> (lane_octet_o[7:0] == CHAR_D21_5
		&& lane_ctrl_o == '0)) else $error("D21.5 stream broken");

endmodule : link_test_pattern_gen

// ---- core/link_test_pkg.sv ----
// Constants for the serial link test-pattern generator
//
// Overview of operation
// - Test select field picks active mode
// - Lane power follows decimation and DDR
// - PRBS bits bypass the 8b10b encoder
// - PRBS taps 6/7, 14/15, 18/23
// - Each lane starts PRBS at unique phase
// - Ramp mode ignores formatter sample data
// - Ramp octet identical on lanes, wraps
// - Transport pattern only when decimating
// - Pattern aligns to SYSREF LMFC event
// - D21.5 mode sends continuous D21.5
// - K28.5 mode sends continuous K28.5
// - Repeated mode restarts alignment forever
// - Sync request restarts code-group sync
// - Entering repeated mode forces sync first
// - RPAT repeats twelve fixed octets encoded
// - Sync request held sends K28.5 on all lanes, except in PRBS, D21.5 and RPAT modes
// - After release, K until LMFC boundary
package link_test_pkg;

	// ----------------------------------------
	// Select field location
	// ----------------------------------------
	localparam logic [15:0] LINK_TEST_ADDR = 16'h0202;
	localparam int          SEL_MSB        = 3;
	localparam int          SEL_LSB        = 0;
	localparam int          SEL_W          = SEL_MSB - SEL_LSB + 1;

	// ----------------------------------------
	// Mode codes
	// ----------------------------------------
	localparam logic [3:0] MODE_NORMAL    = 4'h0;
	localparam logic [3:0] MODE_PRBS7     = 4'h1;
	localparam logic [3:0] MODE_PRBS15    = 4'h2;
	localparam logic [3:0] MODE_PRBS23    = 4'h3;
	localparam logic [3:0] MODE_RAMP      = 4'h4;
	localparam logic [3:0] MODE_TRANSPORT = 4'h5;
	localparam logic [3:0] MODE_D21_5     = 4'h6;
	localparam logic [3:0] MODE_K28_5     = 4'h7;
	localparam logic [3:0] MODE_REP_ALIGN = 4'h8;
	localparam logic [3:0] MODE_RPAT      = 4'h9;

	// ----------------------------------------
	// Characters
	// ----------------------------------------
	localparam logic [7:0] CHAR_K28_5   = 8'hbc;
	localparam logic [7:0] CHAR_K28_0   = 8'h1c;
	localparam logic [7:0] CHAR_K28_3   = 8'h7c;
	localparam logic [7:0] CHAR_D21_5   = 8'hb5;
	localparam logic [7:0] TPORT_HI     = 8'h80;
	localparam logic [7:0] TPORT_LO     = 8'h00;
	localparam logic [7:0] RAMP_START   = 8'h00;
	localparam logic [1:0] ALIGN_MF_LAST = 2'h3;

	// ----------------------------------------
	// PRBS taps (y[n-a] ^ y[n-b]) and seeds
	// ----------------------------------------
	localparam int PRBS7_A  = 6;
	localparam int PRBS7_B  = 7;
	localparam int PRBS15_A = 14;
	localparam int PRBS15_B = 15;
	localparam int PRBS23_A = 18;
	localparam int PRBS23_B = 23;
	localparam int PRBS_W   = 23;
	localparam int SYM_W    = 10;
	localparam logic [15:0] SEED_HI = 16'h5a3c;

	// ----------------------------------------
	// Modified RPAT octets
	// ----------------------------------------
	localparam logic [3:0] RPAT_LAST = 4'hb;
	localparam logic [7:0] RPAT_OCTETS [12] = '{
		8'hbe, 8'hd7, 8'h23, 8'h47, 8'h6b, 8'h8f,
		8'hb3, 8'h14, 8'h5e, 8'hfb, 8'h35, 8'h59};

	// ----------------------------------------
	// Lanes needed per decimation, DDR off
	// ----------------------------------------
	localparam logic [2:0] LANES_DEC4  = 3'h4;
	localparam logic [2:0] LANES_DEC8  = 3'h2;
	localparam logic [2:0] LANES_DEC10 = 3'h2;
	localparam logic [2:0] LANES_DECHI = 3'h1;

endpackage : link_test_pkg

// ---- verif/link_rx_model.sv ----
// Receiver model that drives the sync request
`timescale 1ns/10ps
module link_rx_model (
	// Clock and reset
	input  wire logic       clk_sys_i,
	input  wire logic       rst_i,
	// Bench command and lane 0
	input  wire logic       want_sync_i,
	input  wire logic [7:0] octet_i,
	input  wire logic       ctrl_i,
	// Sync pin
	output logic            sync_req_n_o
);
	logic [2:0] k_run_reg;
	// request, release after K run
	// Release only after four K, as a real receiver would
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			sync_req_n_o <= 1'b1;
			k_run_reg    <= 3'h0;
		end else begin
			if (ctrl_i && octet_i == 8'hbc) begin
				if (k_run_reg != 3'h4)
					k_run_reg <= k_run_reg + 3'h1;
			end else
				k_run_reg <= 3'h0;
			if (want_sync_i)
				sync_req_n_o <= 1'b0;
			else if (k_run_reg == 3'h4)
				sync_req_n_o <= 1'b1;
		end
	end
endmodule : link_rx_model

// ---- verif/serial_link_test_pattern_gen_tb_top.sv ----
// Self-checking bench for the link test-pattern generator
`timescale 1ns/10ps
module serial_link_test_pattern_gen_tb_top;
	import link_test_pkg::*;
	localparam int L = 5;
	logic            clk_sys_i, rst_i, en, ddr, pack, sref, want, sync_n;
	logic            byp;
	logic [3:0]      sel;
	logic [5:0]      dec;
	logic [L*8-1:0]  smp, oct;
	logic [L-1:0]    ctl, pwr;
	logic [L*10-1:0] raw;
	int              n_fail, compares, cyc;

	link_test_pattern_gen #(.LANES(L), .OCT_PF(2), .FRM_PMF(10))
	i_link_test_pattern_gen (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.link_test_select_i(sel), .link_enable_i(en), .decimation_i(dec),
		.ddr_i(ddr), .packing_mode_select_i(pack), .sync_req_n_i(sync_n),
		.sysref_i(sref), .sample_data_i(smp), .lane_octet_o(oct),
		.lane_ctrl_o(ctl), .lane_raw_o(raw), .lane_bypass_o(byp),
		.lane_power_o(pwr));
	link_rx_model i_link_rx_model (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.want_sync_i(want), .octet_i(oct[7:0]), .ctrl_i(ctl[0]),
		.sync_req_n_o(sync_n));

	// ------
	// Helpers
	// ------
	initial begin
		clk_sys_i = 1'b0;
		forever #2 clk_sys_i = ~clk_sys_i;
	end
	task automatic chk(string nm, logic [63:0] ex, logic [63:0] seen);
		compares++;
		if (seen !== ex) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, ex, seen);
		end
	endtask : chk
	task automatic tick(int n);
		repeat (n) @(negedge clk_sys_i);
	endtask : tick
	task automatic wrap_up();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : wrap_up
	task automatic set_mode(logic [3:0] m);
		@(posedge clk_sys_i);
		en <= 1'b0;
		@(posedge clk_sys_i);
		sel <= m;
		@(posedge clk_sys_i);
		en <= 1'b1;
		tick(1);
	endtask : set_mode
	task automatic link_up(logic [3:0] m, logic req);
		int i;
		set_mode(m);
		@(posedge clk_sys_i);
		want <= req;
		sref <= 1'b1;
		@(posedge clk_sys_i);
		want <= 1'b0;
		sref <= 1'b0;
		tick(6);
		i = 0;
		while (!(ctl[0] === 1'b1 && oct[7:0] === CHAR_K28_0) && i < 300) begin
			chk("k_wait", {L{CHAR_K28_5}}, oct);
			chk("k_ctrl", {L{1'b1}}, ctl);
			tick(1);
			i++;
		end
		for (i = 0; i < 80; i++) begin
			if (i % 20 == 0)
				chk("ila_first", {L{CHAR_K28_0}}, oct);
			if (i % 20 == 19)
				chk("ila_last", {L{CHAR_K28_3}}, oct);
			tick(1);
		end
	endtask : link_up

	task automatic t_power();
		logic [5:0] d [4] = '{6'd4, 6'd8, 6'd10, 6'd16};
		int nl [4] = '{4, 2, 2, 1};
		int n;
		set_mode(MODE_PRBS7);
		for (int k = 0; k < 8; k++) begin
			@(posedge clk_sys_i);
			dec <= d[k % 4];
			ddr <= 1'(k / 4);
			tick(3);
			n = k < 4 ? nl[k] : (nl[k - 4] + 1) >> 1;
			chk("power", 64'((1 << n) - 1), pwr);
		end
		@(posedge clk_sys_i);
		dec <= 6'd4;
		ddr <= 1'b0;
	endtask : t_power
	task automatic t_cont();
		int j;
		set_mode(MODE_D21_5);
		tick(2);
		chk("d21", {L{CHAR_D21_5}}, oct);
		chk("d21_ctl", 0, ctl);
		chk("d21_byp", 0, byp);
		set_mode(MODE_K28_5);
		tick(2);
		chk("k28", {L{CHAR_K28_5}}, oct);
		chk("k28_ctl", {L{1'b1}}, ctl);
		set_mode(MODE_RPAT);
		tick(2);
		j = 0;
		while (oct[7:0] !== RPAT_OCTETS[0] && j < 12) begin
			tick(1);
			j++;
		end
		for (j = 0; j < 24; j++) begin
			chk("rpat", {L{RPAT_OCTETS[j % 12]}}, oct);
			tick(1);
		end
	endtask : t_cont
	task automatic t_prbs();
		int a [3] = '{6, 14, 18};
		int b [3] = '{7, 15, 23};
		logic [99:0] s;
		logic err;
		for (int m = 0; m < 3; m++) begin
			set_mode(4'(m + 1));
			tick(2);
			chk("bypass", 1, byp);
			chk("phase", 1, raw[9:0] !== raw[19:10]);
			for (int c = 0; c < 100; c++) begin
				s[c] = raw[9 - c % 10];
				if (c % 10 == 9)
					tick(1);
			end
			err = 1'b0;
			for (int n = b[m]; n < 100; n++)
				err = err | (s[n] ^ s[n - a[m]] ^ s[n - b[m]]);
			chk("prbs", 0, err);
			chk("nonzero", 1, |s);
		end
	endtask : t_prbs
	task automatic t_link();
		logic [L*8-1:0] e;
		link_up(MODE_NORMAL, 1'b1);
		chk("data", smp, oct);
		link_up(4'hf, 1'b1);
		chk("unassigned", smp, oct);
		link_up(MODE_RAMP, 1'b1);
		for (int j = 0; j < 300; j++) begin
			chk("ramp", {L{8'(j)}}, oct);
			tick(1);
		end
		link_up(MODE_TRANSPORT, 1'b1);
		chk("tport0", 0, oct);
		tick(1);
		for (int i = 0; i < L; i++)
			e[8 * i +: 8] = {5'h0, 2'(i), pack};
		chk("tport1", e, oct);
		tick(1);
		chk("tport2", {L{TPORT_HI}}, oct);
		@(posedge clk_sys_i);
		pack <= 1'b0;
		tick(19);
		for (int i = 0; i < L; i++)
			e[8 * i +: 8] = {5'h0, 2'(i), 1'b0};
		chk("tport_fmt", e, oct);
	endtask : t_link
	task automatic t_rep();
		link_up(MODE_REP_ALIGN, 1'b0);
		chk("rep_again", {L{CHAR_K28_0}}, oct);
		@(posedge clk_sys_i);
		want <= 1'b1;
		@(posedge clk_sys_i);
		want <= 1'b0;
		tick(5);
		chk("rep_sync", {L{CHAR_K28_5}}, oct);
	endtask : t_rep

	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			wrap_up();
		end
	end
	initial begin
		{n_fail, compares, cyc} = '0;
		{rst_i, pack} = 2'b11;
		{en, ddr, sref, want} = 4'h0;
		sel = MODE_NORMAL;
		dec = 6'd4;
		smp = 40'h1122334455;
		repeat (12) @(posedge clk_sys_i);
		tick(1);
		chk("rst_oct", 0, oct);
		chk("rst_ctl", 0, ctl);
		chk("rst_pwr", 0, pwr);
		chk("rst_byp", 0, byp);
		chk("rst_raw", 0, raw);
		@(posedge clk_sys_i);
		rst_i <= 1'b0;
		t_power();
		t_cont();
		t_prbs();
		t_link();
		t_rep();
		wrap_up();
	end
endmodule : serial_link_test_pattern_gen_tb_top
